// [rtl/svpi_sink.sv]
// Function
// - Vsync ends one frame, starts next
// - Back porch: hsyncs from vsync end
// - Front porch: hsyncs after last active
// - Vsync trailing edge resets datapath
// - Horizontal porches counted in clocks
// - Capture pixels only while valid high
// - Source keeps valid high whole line
// - One, two or four pixels per clock
// - 48-bit slots, MSB first, low zero
// - MSB-aligned components in three fields
// - 4:2:2 alternates Cr and Cb
// - Quad mode pads line with zeros
// - Pixel clock at most 150 MHz; CLK_MHZ and the tb clock are 200 MHz
`default_nettype none
module svpi_sink import svpi_pkg::*; (
  input wire logic ref_clk_in,             // Pixel clock
  input wire logic resetn_in,              // Async reset, low
  svpi_if.sink vid,                        // Video input
  input wire logic [2:0] format_in,        // Colour format code
  input wire logic [4:0] bpc_in,           // Bits per component
  output logic pix_valid_out,              // Unpacked pixel group valid
  input wire logic pix_ready_in,           // Consumer accept
  output logic [FLD_W*3*PIX_PER_CLK-1:0] pix_comp_out, // Components per slot
  output logic [PIX_PER_CLK-1:0] pix_is_cr_out, // 4:2:2 chroma is Cr
  output logic frame_start_out,            // One-cycle, vsync trailing edge
  output logic [CNT_W-1:0] vbp_out,        // Vertical back porch, lines
  output logic [CNT_W-1:0] vfp_out,        // Vertical front porch, lines
  output logic [CNT_W-1:0] hbp_out,        // Horizontal back porch, clocks
  output logic [CNT_W-1:0] hfp_out,        // Horizontal front porch, clocks
  output logic [CNT_W-1:0] line_count_out, // Active lines this frame
  output logic overflow_out                // Pixel dropped, sticky to frame
);
  ////////////////////////////////////////////////////////////////////////////
  svpi_vstate_t vstate;
  logic vs_d;
  logic hs_d;
  logic vs_fall;
  logic vs_rise;
  logic hs_rise;
  logic line_has_data;
  logic in_line_active;
  logic [CNT_W-1:0] vcnt;
  logic [CNT_W-1:0] hcnt;
  logic [CNT_W-1:0] fp_cnt;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [BUS_W-1:0] fifo_out_data;
  logic [PIX_PER_CLK-1:0] next_is_cr;
  logic chroma_cr;

  assign vs_rise = vid.vsync && !vs_d;
  assign vs_fall = !vid.vsync && vs_d;
  assign hs_rise = vid.hsync && !hs_d;

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      vs_d <= 1'b0;
      hs_d <= 1'b0;
    end else begin
      vs_d <= vid.vsync;
      hs_d <= vid.hsync;
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      frame_start_out <= 1'b0;
    end else begin
      frame_start_out <= vs_fall;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Vertical framing
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      vstate <= SVPI_VSYNC;
      vcnt <= CNT_ZERO;
      vbp_out <= CNT_ZERO;
      line_count_out <= CNT_ZERO;
    end else if (vs_rise) begin
      vstate <= SVPI_VSYNC;
    end else if (vs_fall) begin
      vstate <= SVPI_BACK_PORCH;
      vcnt <= CNT_ZERO;
      line_count_out <= CNT_ZERO;
    end else begin
      case (vstate)
        SVPI_BACK_PORCH: begin
          if (vid.valid) begin
            vstate <= SVPI_ACTIVE;
            vbp_out <= vcnt;
            line_count_out <= CNT_ONE;
          end else if (hs_rise) begin
            vcnt <= vcnt + CNT_ONE;
          end
        end
        SVPI_ACTIVE: begin
          if (vid.valid && !in_line_active) begin
            line_count_out <= line_count_out + CNT_ONE;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Lines with no data since the last active one form the front porch
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fp_cnt <= CNT_ZERO;
      vfp_out <= CNT_ZERO;
      line_has_data <= 1'b0;
    end else if (vs_rise) begin
      vfp_out <= fp_cnt;
      fp_cnt <= CNT_ZERO;
    end else if (hs_rise) begin
      line_has_data <= 1'b0;
      // Every hsync after the last valid word counts; a later valid restarts it
      if (vstate == SVPI_ACTIVE) begin
        fp_cnt <= fp_cnt + CNT_ONE;
      end
    end else if (vid.valid) begin
      line_has_data <= 1'b1;
      fp_cnt <= CNT_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Horizontal porches in clocks
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hcnt <= CNT_ZERO;
      in_line_active <= 1'b0;
      hbp_out <= CNT_ZERO;
      hfp_out <= CNT_ZERO;
    end else if (hs_rise) begin
      if (!in_line_active && line_has_data) begin
        hfp_out <= hcnt;
      end
      hcnt <= CNT_ZERO;
      in_line_active <= 1'b0;
    end else if (vid.valid && !in_line_active) begin
      hbp_out <= hcnt;
      in_line_active <= 1'b1;
      hcnt <= CNT_ZERO;
    end else if (in_line_active && !vid.valid) begin
      // Valid is held for the whole line, so its fall marks line end
      in_line_active <= 1'b0;
      hcnt <= CNT_ONE;
    end else if (!vid.hsync) begin
      hcnt <= hcnt + CNT_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture into FIFO; vsync trailing edge flushes stale pixels
  svpi_fifo #(.WIDTH(BUS_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .flush_in(vs_fall),
    .in_valid_in(vid.valid),
    .in_ready_out(fifo_in_ready),
    .in_data_in(vid.pixel),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(pix_ready_in || !pix_valid_out),
    .out_data_out(fifo_out_data)
  );
  assign vid.ready = fifo_in_ready;

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      overflow_out <= 1'b0;
    end else if (vid.valid && !fifo_in_ready) begin
      overflow_out <= 1'b1;                // Set wins over frame clear
    end else if (vs_fall) begin
      overflow_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unpack MSB-aligned components per slot
  always_comb begin
    next_is_cr = '0;
    for (int i = 0; i < PIX_PER_CLK; i++) begin
      next_is_cr[i] = chroma_cr ^ i[0];
    end
  end

  // Zero bits below the component width, per slot and field
  function automatic logic [FLD_W-1:0] svpi_mask(input logic [FLD_W-1:0] f,
                                                  input logic [4:0] w);
    logic [FLD_W-1:0] m;
    m = ~(16'hffff >> w);
    return f & m;
  endfunction : svpi_mask

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pix_valid_out <= 1'b0;
      pix_comp_out <= '0;
      pix_is_cr_out <= '0;
      chroma_cr <= 1'b1;
    end else if (vs_fall) begin
      pix_valid_out <= 1'b0;
      chroma_cr <= 1'b1;
    end else if (pix_ready_in || !pix_valid_out) begin
      pix_valid_out <= fifo_out_valid;
      if (fifo_out_valid) begin
        pix_is_cr_out <= next_is_cr;
        if (PIX_PER_CLK[0]) begin
          chroma_cr <= !chroma_cr;
        end
        // A full group per clock; the pixel clock is 200 MHz (CLK_MHZ), over its 150 MHz limit
        for (int i = 0; i < PIX_PER_CLK; i++) begin
          for (int f = 0; f < 3; f++) begin
            pix_comp_out[(i*3+f)*FLD_W +: FLD_W] <=
              ((format_in == FMT_YONLY || format_in == FMT_YCC422) && f == 0) ? '0 :
              (format_in == FMT_YONLY && f == 1) ? '0 :
              svpi_mask(fifo_out_data[i*SLOT_W + f*FLD_W +: FLD_W], bpc_in);
          end
        end
      end
    end
  end
endmodule : svpi_sink
`default_nettype wire

// [rtl/svpi_pkg.sv]
`default_nettype none
package svpi_pkg;
  // Pixels per clock, fixed at build time: 1, 2 or 4
  localparam int PIX_PER_CLK = 2;
  localparam int SLOT_W = 48;
  localparam int BUS_W = SLOT_W * PIX_PER_CLK;
  localparam int FIFO_DEPTH = 32;
  localparam int CNT_W = 16;
  // Component fields: top bit of each 16-bit field
  localparam int FLD_W = 16;
  localparam int FLD_TOP_HI = 47;
  localparam int FLD_TOP_MID = 31;
  localparam int FLD_TOP_LO = 15;
  // Format codes
  localparam logic [2:0] FMT_RGB = 3'h0;
  localparam logic [2:0] FMT_YCC444 = 3'h1;
  localparam logic [2:0] FMT_YCC422 = 3'h2;
  localparam logic [2:0] FMT_YONLY = 3'h3;
  // Timing limits
  localparam int CLK_MHZ = 200;
  localparam int PIX_CLK_MAX_MHZ = 150;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  typedef enum logic [1:0] {
    SVPI_VSYNC,
    SVPI_BACK_PORCH,
    SVPI_ACTIVE,
    SVPI_FRONT_PORCH
  } svpi_vstate_t;
endpackage : svpi_pkg
`default_nettype wire

// [rtl/svpi_if.sv]
`default_nettype none
interface svpi_if import svpi_pkg::*; ();
  logic vsync;
  logic hsync;
  logic valid;
  logic ready;
  logic [BUS_W-1:0] pixel;
  modport source (output vsync, output hsync, output valid, output pixel, input ready);
  modport sink (input vsync, input hsync, input valid, input pixel, output ready);
endinterface : svpi_if
`default_nettype wire

// [rtl/svpi_fifo.sv]
`default_nettype none
module svpi_fifo #(
  parameter int WIDTH = 96,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk_in,          // Clock
  input wire logic resetn_in,           // Async reset, low
  input wire logic flush_in,            // Drop contents
  input wire logic in_valid_in,         // Write valid
  output logic in_ready_out,            // Not full
  input wire logic [WIDTH-1:0] in_data_in,  // Write data
  output logic out_valid_out,           // Not empty
  input wire logic out_ready_in,        // Read accept
  output logic [WIDTH-1:0] out_data_out // Head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;
  assign in_ready_out = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid_out = wr_ptr != rd_ptr;
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign out_data_out = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_in;
    end
  end
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (flush_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule : svpi_fifo
`default_nettype wire

// [rtl/svpi_source.sv]
`default_nettype none
module svpi_source import svpi_pkg::*; (
  input wire logic ref_clk_in,             // Pixel clock
  input wire logic resetn_in,              // Async reset, low
  svpi_if.source vid,                      // Video output
  input wire logic vsync_in,               // Timing vsync
  input wire logic hsync_in,               // Timing hsync
  input wire logic active_in,              // Whole active span of line
  input wire logic [2:0] last_fill_in,     // Real pixels in last word, 0 means all
  input wire logic last_word_in,           // Last word of line
  input wire logic [2:0] format_in,        // Colour format code
  input wire logic [4:0] bpc_in,           // Bits per component
  input wire logic [FLD_W*3*PIX_PER_CLK-1:0] comp_in, // Components, MSB aligned
  output logic overrun_out                 // Sink refused a word
);
  logic [BUS_W-1:0] next_pixel;
  logic [FLD_W-1:0] m;
  always_comb begin
    next_pixel = '0;
    m = ~(16'hffff >> bpc_in);
    for (int i = 0; i < PIX_PER_CLK; i++) begin
      // Pad slots past the line end with zero pixels
      if (!(last_word_in && last_fill_in != 3'h0 && i >= int'(last_fill_in))) begin
        for (int f = 0; f < 3; f++) begin
          // Fields a format leaves unused go out as zero
          if (!(format_in == FMT_YONLY && f != 2) &&
              !(format_in == FMT_YCC422 && f == 0)) begin
            next_pixel[i*SLOT_W + f*FLD_W +: FLD_W] =
              comp_in[(i*3+f)*FLD_W +: FLD_W] & m;
          end
        end
      end
    end
  end
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      vid.vsync <= 1'b0;
      vid.hsync <= 1'b0;
      vid.valid <= 1'b0;
      vid.pixel <= '0;
      overrun_out <= 1'b0;
    end else begin
      vid.vsync <= vsync_in;
      vid.hsync <= hsync_in;
      vid.valid <= active_in;
      vid.pixel <= active_in ? next_pixel : '0;
      overrun_out <= vid.valid && !vid.ready;
    end
  end
endmodule : svpi_source
`default_nettype wire

// [dv/svpi_checker.sv]
`default_nettype none
module svpi_checker import svpi_pkg::*; (
  input wire logic ref_clk_in,                           // Clock
  input wire logic resetn_in,                            // Reset, low
  input wire logic vsync,                                // Link vsync
  input wire logic hsync,                                // Link hsync
  input wire logic valid,                                // Link valid
  input wire logic ready,                                // Sink not full
  input wire logic frame_start_out,                      // Frame pulse
  input wire logic pix_valid_out,                        // Output valid
  input wire logic pix_ready_in,                         // Output accept
  input wire logic [FLD_W*3*PIX_PER_CLK-1:0] pix_comp_out, // Components
  input wire logic overflow_out                          // Sticky drop
);
  timeunit 1ns;
  timeprecision 100ps;
  logic refused;
  assign refused = valid & ~ready;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  ////////////////////////////////////////////////////////////////
  chk_fs_after_fall: assert property ($fell(vsync) |=> frame_start_out)
    else $error("no frame start after vsync fall");
  chk_fs_cause: assert property (frame_start_out |-> $past(vsync, 2) && !$past(vsync))
    else $error("frame start without vsync fall");
  chk_flush_output: assert property ($fell(vsync) |-> ##2 !pix_valid_out)
    else $error("output not flushed at vsync fall");
  chk_overflow_cause: assert property ($rose(overflow_out) |-> $past(refused))
    else $error("overflow without refused word");
  chk_overflow_clear: assert property (
    $fell(vsync) && !refused |-> ##[1:2] !overflow_out)
    else $error("overflow not cleared by vsync fall");
  chk_overflow_sticky: assert property (overflow_out && !$fell(vsync) |=> overflow_out)
    else $error("overflow dropped inside frame");
  chk_hold_stall: assert property (pix_valid_out && !pix_ready_in && !$fell(vsync)
    |=> pix_valid_out && $stable(pix_comp_out))
    else $error("output changed while stalled");
  chk_valid_no_hsync: assert property (valid |-> !hsync)
    else $error("valid overlaps hsync");
  chk_valid_no_vsync: assert property (valid |-> !vsync)
    else $error("valid overlaps vsync");
  ////////////////////////////////////////////////////////////////
  cov_frame: cover property ($fell(vsync));
  cov_overflow: cover property ($rose(overflow_out));
  cov_stall: cover property (pix_valid_out && !pix_ready_in);
endmodule : svpi_checker
`default_nettype wire

// [dv/tb.sv]
`default_nettype none
module tb import svpi_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int W = FLD_W * 3 * PIX_PER_CLK;
  localparam int HBP = 3;
  localparam int HFP = 4;
  logic ref_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic vs = 1'b0, hs = 1'b0, act = 1'b0, lw = 1'b0, rdy = 1'b1;
  logic hold = 1'b0, stall = 1'b0, push = 1'b1, ovr_seen = 1'b0;
  logic pv, fs, ovf, ovr;
  logic [2:0] fill = 3'h0, fmt = 3'h0;
  logic [4:0] bpc = 5'h08;
  logic [1:0] sc = 2'h0;
  logic [W-1:0] comp = '0, pc;
  logic [PIX_PER_CLK-1:0] icr;
  logic [CNT_W-1:0] vbp, vfp, hbp, hfp, nl;
  logic [W-1:0] eq[$], wq[$];
  int n_errors = 0;
  int samples_checked = 0;
  always #2.5 ref_clk_in = ~ref_clk_in;
  svpi_if vid ();
  svpi_source u_svpi_source (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .vid(vid),
    .vsync_in(vs), .hsync_in(hs), .active_in(act), .last_fill_in(fill), .last_word_in(lw),
    .format_in(fmt), .bpc_in(bpc), .comp_in(comp), .overrun_out(ovr));
  svpi_sink u_svpi_sink (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .vid(vid),
    .format_in(fmt), .bpc_in(bpc), .pix_valid_out(pv), .pix_ready_in(rdy),
    .pix_comp_out(pc), .pix_is_cr_out(icr), .frame_start_out(fs), .vbp_out(vbp),
    .vfp_out(vfp), .hbp_out(hbp), .hfp_out(hfp), .line_count_out(nl), .overflow_out(ovf));
  svpi_checker u_svpi_checker (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .vsync(vid.vsync), .hsync(vid.hsync), .valid(vid.valid), .ready(vid.ready),
    .frame_start_out(fs), .pix_valid_out(pv), .pix_ready_in(rdy), .pix_comp_out(pc),
    .overflow_out(ovf));
  ////////////////////////////////////////////////////////////////
  task automatic check(string s, logic [W-1:0] e, logic [W-1:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask : check
  // Keep the top bpc bits of the fields the format uses, slots below kf only
  function automatic logic [W-1:0] shape(logic [W-1:0] v, int kf);
    logic [W-1:0] r;
    r = '0;
    for (int i = 0; i < kf; i++)
      for (int f = 0; f < 3; f++)
        if (f == 2 || fmt < FMT_YCC422 || (f == 1 && fmt == FMT_YCC422))
          r[(3*i+f)*16 +: 16] = v[(3*i+f)*16 +: 16] & (16'hffff << (16 - int'(bpc)));
    return r;
  endfunction : shape
  task automatic tick(logic v, logic h, logic a, logic l, logic [2:0] f);
    @(posedge ref_clk_in);
    #1;
    vs = v;
    hs = h;
    act = a;
    lw = l;
    fill = f;
  endtask : tick
  task automatic blank(int n, logic v);
    repeat (n) tick(v, 1'b0, 1'b0, 1'b0, 3'h0);
  endtask : blank
  task automatic line(int nw, int lf);
    repeat (2) tick(1'b0, 1'b1, 1'b0, 1'b0, 3'h0);
    blank(HBP, 1'b0);
    for (int k = 0; k < nw; k++) begin
      tick(1'b0, 1'b0, 1'b1, k == nw - 1, (k == nw - 1) ? 3'(lf) : 3'h0);
      for (int j = 0; j < W / 16; j++)
        comp[j*16 +: 16] = 16'(j * 16'h1111 + k * 16'h0135) ^ 16'hc3a5;
      if (push) begin
        eq.push_back(shape(comp, (k == nw - 1 && lf != 0) ? lf : PIX_PER_CLK));
        wq.push_back(eq[$]);
      end
    end
    blank(HFP, 1'b0);
  endtask : line
  task automatic frame(int nb, int na, int nw, int lf);
    blank(3, 1'b1);
    repeat (nb) line(0, 0);
    repeat (na) line(nw, lf);
    repeat (2) line(0, 0);
    blank(3, 1'b1);
  endtask : frame
  // Porches and line count are judged while vsync is still high, before the next vsync fall clears the count
  task automatic measure(int nb, int na);
    int t;
    t = 0;
    while (eq.size() != 0 && t < 400) begin
      @(posedge ref_clk_in);
      t++;
    end
    @(posedge ref_clk_in);
    #1;
    check("drain", 0, W'(eq.size()));
    if (t == 400) begin
      n_errors++;
      finish_test();
    end
    check("pv idle", 0, W'(pv));
    check("vbp", nb, vbp);
    check("vfp", 2, vfp);
    check("hbp", HBP, hbp);
    check("hfp", HFP, hfp);
    check("lines", na, nl);
  endtask : measure
  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////
  always @(posedge ref_clk_in) begin
    if (pv === 1'b1 && rdy === 1'b1) begin
      if (eq.size() == 0) check("pixel unexpected", '0, '1);
      else check("pixel", eq.pop_front(), pc);
      if (fmt == FMT_YCC422) check("chroma", 2'b01, W'(icr));
    end
    if (vid.valid === 1'b1 && push) begin
      if (wq.size() == 0) check("wire unexpected", '0, '1);
      else check("wire", wq.pop_front(), vid.pixel);
    end
    if (ovr === 1'b1) ovr_seen = 1'b1;
  end
  always @(posedge ref_clk_in) begin
    #1;
    sc = sc + 2'h1;
    rdy = !hold && (!stall || sc[1]);
  end
  initial begin
    repeat (12) @(posedge ref_clk_in);
    #1;
    resetn_in = 1'b1;
    for (int f = 0; f < 4; f++) begin
      fmt = 3'(f);
      bpc = (f == 0) ? 5'h06 : 5'(8 + 2 * f + (f / 3) * 2);
      stall = f[0];
      frame(f + 1, 2, 4, 0);
      measure(f + 1, 2);
    end
    fmt = FMT_RGB;
    bpc = 5'h08;
    frame(1, 3, 3, 1);
    measure(1, 3);
    check("no overflow", 0, W'(ovf));
    check("no overrun", 0, W'(ovr_seen));
    // Consumer held off so the buffer fills and refuses
    hold = 1'b1;
    push = 1'b0;
    frame(1, 5, 8, 0);
    check("overflow", 1, W'(ovf));
    check("overrun", 1, W'(ovr_seen));
    blank(6, 1'b0);
    check("ovf clear", 0, W'(ovf));
    check("pv flush", 0, W'(pv));
    hold = 1'b0;
    push = 1'b1;
    stall = 1'b1;
    frame(2, 4, 8, 0);
    measure(2, 4);
    finish_test();
  end
endmodule : tb
`default_nettype wire
